// ### hdl/pfta_pkg.sv
/*
 * pfta_pkg: shared constants and types of the program flash table access block.
 * assumes: a 32-bit classic wishbone bus, byte addresses, data in the low byte.
 */
package pfta_pkg;
    // register byte offsets
    localparam logic [7:0] PFTA_OFF_CONTROL = 8'h00;
    localparam logic [7:0] PFTA_OFF_UNLOCK = 8'h04;
    localparam logic [7:0] PFTA_OFF_LATCH = 8'h08;
    localparam logic [7:0] PFTA_OFF_PTR_LOW = 8'h0C;
    localparam logic [7:0] PFTA_OFF_PTR_HIGH = 8'h10;
    localparam logic [7:0] PFTA_OFF_PTR_UPPER = 8'h14;
    localparam logic [7:0] PFTA_OFF_TBL_CMD = 8'h18;
    localparam logic [7:0] PFTA_OFF_STATUS = 8'h1C;
    // control register bit positions
    localparam int PFTA_BIT_CODE_SEL = 7;
    localparam int PFTA_BIT_CFG_SEL = 6;
    localparam int PFTA_BIT_ERASE_SEL = 4;
    localparam int PFTA_BIT_ABORTED = 3;
    localparam int PFTA_BIT_PERMIT = 2;
    localparam int PFTA_BIT_LAUNCH = 1;
    localparam int PFTA_BIT_FETCH = 0;
    // status register bit positions
    localparam int PFTA_BIT_DONE = 0;
    localparam int PFTA_BIT_BUSY = 1;
    // table command fields
    localparam int PFTA_BIT_STORE = 2;
    localparam logic [1:0] PFTA_PTR_KEEP = 2'h0;
    localparam logic [1:0] PFTA_PTR_POST_INC = 2'h1;
    localparam logic [1:0] PFTA_PTR_POST_DEC = 2'h2;
    localparam logic [1:0] PFTA_PTR_PRE_INC = 2'h3;
    // unlock key bytes
    localparam logic [7:0] PFTA_KEY_FIRST = 8'h55;
    localparam logic [7:0] PFTA_KEY_SECOND = 8'hAA;
    // target space encoding
    localparam logic [1:0] PFTA_TGT_EEPROM = 2'h0;
    localparam logic [1:0] PFTA_TGT_FLASH = 2'h1;
    localparam logic [1:0] PFTA_TGT_CONFIG = 2'h2;
    // widths and reset values
    localparam int PFTA_PTR_W = 22;
    localparam int PFTA_HOLD_N = 8;
    localparam logic [7:0] PFTA_LATCH_RST = 8'h00;
    localparam logic [21:0] PFTA_PTR_RST = 22'h000000;
    // self-timed cycle length
    localparam int PFTA_PROG_TIME_MS = 2;
    localparam int PFTA_CLK_KHZ = 20000;
    localparam int PFTA_PROG_CYC = PFTA_PROG_TIME_MS * PFTA_CLK_KHZ;
    // unlock sequence tracker
    typedef enum logic [1:0] {
        PFTA_UL_IDLE,
        PFTA_UL_ONE,
        PFTA_UL_TWO
    } pfta_ul_t;
endpackage

// ### hdl/pfta_timer.sv
/*
 * pfta_timer: internal programming timer that ends a self-timed cycle.
 * assumes: start is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
module pfta_timer #(
    parameter int CYCLES = 40000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic done_o
);
    localparam int CW = $clog2(CYCLES + 1);

    // timer state
    typedef struct packed {
        logic run;
        logic [CW-1:0] cnt;
        logic done;
    } pfta_tmr_t;

    pfta_tmr_t st_ff;
    pfta_tmr_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // count down from start, pulse done on the last cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (rst_i) begin
            nxt_st = '0;
        end else if (start_i) begin
            nxt_st.run = 1'b1;
            nxt_st.cnt = CW'(CYCLES);
        end else if (st_ff.run) begin
            // last count ends the cycle
            if (st_ff.cnt <= CW'(1)) begin
                nxt_st.run = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt - CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    assign done_o = st_ff.done;
endmodule

// ### hdl/pfta_core.sv
/*
 * pfta_core: control, unlock, table pointer, table latch and holding
 * registers for self-access to program flash, as a wishbone slave.
 * assumes: the flash array runs on clk_i, returns a 16-bit word in the same
 * cycle that fl_rd_o is high, and programs prog_data_o when prog_start_o pulses.
 */
// Behaviour
// - unlock register reads zero, holds nothing
// - code select one means program flash
// - config select overrides, targets configuration space
// - erase select erases row, cleared when done
// - launch refused while modify permit clear
// - clearing permit never stops running cycle
// - reset during timed cycle sets aborted
// - abort keeps code and config selects
// - launch set-only, hardware clears at end
// - fetch one cycle, refused for program space
// - done flag set by hardware, firmware clears
// - table latch is eight-bit data register
// - three pointer bytes form 22-bit address
// - four pointer actions touch low 21 bits
// - table read uses all 22 pointer bits
// - table write picks holding register by low three
// - long write block from upper 19 bits
// - row erase 64-byte block, latch unused
// - pointer bit zero picks word byte
// - execution stalls until timer ends cycle
// - table writes fill eight holding registers only
`timescale 1ns/1ps
module pfta_core
    import pfta_pkg::*;
#(
    parameter int PROG_CYCLES = PFTA_PROG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // flash array read port
    output logic [21:0] fl_addr_o,
    output logic fl_rd_o,
    input wire logic [15:0] fl_word_i,
    // self-timed program port
    output logic prog_start_o,
    output logic prog_erase_o,
    output logic [1:0] prog_target_o,
    output logic [21:0] prog_addr_o,
    output logic [63:0] prog_data_o,
    // data eeprom read strobe
    output logic ee_read_o,
    // core stall and completion flag
    output logic stall_o,
    output logic nvm_done_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // state of the block

    typedef struct packed {
        logic code_space_select;       // program vs eeprom
        logic config_space_select;     // configuration space
        logic erase_sel;               // row erase on launch
        logic aborted_flag;            // cycle cut by reset
        logic modify_permit;           // allows launches
        logic launch;                  // self-timed cycle running
        logic fetch;                   // eeprom read launch
        pfta_ul_t ul;                  // unlock tracker
        logic [7:0] table_latch;       // byte mover
        logic [21:0] table_pointer;    // byte address
        logic [7:0][7:0] hold;         // eight holding registers
        logic rd_pend;                 // flash word due
        logic rd_lsb;                  // byte select of pending read
        logic done_flag;               // completion flag
        logic ack;                     // bus answer
        logic [31:0] dat;              // bus read data
        logic [21:0] fl_addr;          // flash read address
        logic fl_rd;                   // flash read strobe
        logic prog_start;              // program start pulse
        logic [1:0] prog_target;       // program target space
        logic [21:0] prog_addr;        // block base address
        logic ee_read;                 // eeprom read strobe
    } pfta_state_t;

    pfta_state_t st_ff;
    pfta_state_t nxt_st;

    logic tmr_done;                    // end of timed cycle
    logic acc;                         // access taken this cycle
    logic wr;                          // write taken this cycle
    logic [7:0] wbyte;                 // written byte
    logic [21:0] eff_ptr;              // pointer used by table op
    logic [21:0] upd_ptr;              // pointer after table op
    logic [1:0] mode;                  // pointer action
    logic [7:0] ctl_rd;                // control read image
    logic [1:0] tgt;                   // selected space

    ////////////////////////////////////////////////////////////////////////
    // internal programming timer

    pfta_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(st_ff.prog_start),
        .done_o(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // access decode and helpers

    always_comb begin
        // first cycle of a request only
        acc = wb_cyc_i && wb_stb_i && !st_ff.ack;
        wr = acc && wb_we_i && wb_sel_i[0];
        wbyte = wb_dat_i[7:0];
        mode = wb_dat_i[1:0];
        // pre-increment moves only the low 21 bits
        if (mode == PFTA_PTR_PRE_INC) begin
            eff_ptr = {st_ff.table_pointer[21], st_ff.table_pointer[20:0] + 21'h000001};
        end else begin
            eff_ptr = st_ff.table_pointer;
        end
        // pointer after the access
        case (mode)
            PFTA_PTR_POST_INC: begin
                upd_ptr = {st_ff.table_pointer[21], st_ff.table_pointer[20:0] + 21'h000001};
            end
            PFTA_PTR_POST_DEC: begin
                upd_ptr = {st_ff.table_pointer[21], st_ff.table_pointer[20:0] - 21'h000001};
            end
            PFTA_PTR_PRE_INC: begin
                upd_ptr = eff_ptr;
            end
            default: begin
                upd_ptr = st_ff.table_pointer;
            end
        endcase
        // target space, config wins over code select
        if (st_ff.config_space_select) begin
            tgt = PFTA_TGT_CONFIG;
        end else if (st_ff.code_space_select) begin
            tgt = PFTA_TGT_FLASH;
        end else begin
            tgt = PFTA_TGT_EEPROM;
        end
        // control image, bit 5 reads zero
        ctl_rd = 8'h00;
        ctl_rd[PFTA_BIT_CODE_SEL] = st_ff.code_space_select;
        ctl_rd[PFTA_BIT_CFG_SEL] = st_ff.config_space_select;
        ctl_rd[PFTA_BIT_ERASE_SEL] = st_ff.erase_sel;
        ctl_rd[PFTA_BIT_ABORTED] = st_ff.aborted_flag;
        ctl_rd[PFTA_BIT_PERMIT] = st_ff.modify_permit;
        ctl_rd[PFTA_BIT_LAUNCH] = st_ff.launch;
        ctl_rd[PFTA_BIT_FETCH] = st_ff.fetch;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        // pulses last one cycle
        nxt_st.fl_rd = 1'b0;
        nxt_st.prog_start = 1'b0;
        nxt_st.ee_read = 1'b0;
        nxt_st.rd_pend = 1'b0;
        nxt_st.ack = acc;
        nxt_st.dat = 32'h00000000;

        // fetch lasts one cycle then hardware clears it
        if (st_ff.fetch) begin
            nxt_st.fetch = 1'b0;
        end

        // flash word returns, lsb picks the byte
        if (st_ff.rd_pend) begin
            nxt_st.table_latch = st_ff.rd_lsb ? fl_word_i[15:8] : fl_word_i[7:0];
        end

        // end of the timed cycle
        if (tmr_done && st_ff.launch) begin
            nxt_st.launch = 1'b0;
            nxt_st.erase_sel = 1'b0;
        end

        // bus read data
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                PFTA_OFF_CONTROL: begin
                    nxt_st.dat = {24'h000000, ctl_rd};
                end
                PFTA_OFF_LATCH: begin
                    nxt_st.dat = {24'h000000, st_ff.table_latch};
                end
                PFTA_OFF_PTR_LOW: begin
                    nxt_st.dat = {24'h000000, st_ff.table_pointer[7:0]};
                end
                PFTA_OFF_PTR_HIGH: begin
                    nxt_st.dat = {24'h000000, st_ff.table_pointer[15:8]};
                end
                PFTA_OFF_PTR_UPPER: begin
                    nxt_st.dat = {26'h0000000, st_ff.table_pointer[21:16]};
                end
                PFTA_OFF_STATUS: begin
                    nxt_st.dat = {30'h00000000, st_ff.launch, st_ff.done_flag};
                end
                default: begin
                    // unlock has no storage and reads zero
                    nxt_st.dat = 32'h00000000;
                end
            endcase
        end

        // unlock tracker: any other access breaks the pair
        if (acc) begin
            nxt_st.ul = PFTA_UL_IDLE;
            if (wr && wb_adr_i == PFTA_OFF_UNLOCK) begin
                if (wbyte == PFTA_KEY_FIRST) begin
                    nxt_st.ul = PFTA_UL_ONE;
                end else if (wbyte == PFTA_KEY_SECOND && st_ff.ul == PFTA_UL_ONE) begin
                    nxt_st.ul = PFTA_UL_TWO;
                end
            end
        end

        // register writes
        if (wr) begin
            case (wb_adr_i)
                PFTA_OFF_CONTROL: begin
                    nxt_st.code_space_select = wbyte[PFTA_BIT_CODE_SEL];
                    nxt_st.config_space_select = wbyte[PFTA_BIT_CFG_SEL];
                    nxt_st.aborted_flag = wbyte[PFTA_BIT_ABORTED];
                    // permit may drop mid-cycle harmlessly
                    nxt_st.modify_permit = wbyte[PFTA_BIT_PERMIT];
                    // erase select frozen while a cycle runs
                    if (!st_ff.launch) begin
                        nxt_st.erase_sel = wbyte[PFTA_BIT_ERASE_SEL];
                    end
                    // launch: set-only, needs permit and unlock pair
                    if (wbyte[PFTA_BIT_LAUNCH] && !st_ff.launch && st_ff.modify_permit
                        && st_ff.ul == PFTA_UL_TWO) begin
                        nxt_st.launch = 1'b1;
                        nxt_st.prog_start = 1'b1;
                        nxt_st.prog_target = tgt;
                        if (st_ff.erase_sel) begin
                            // 64-byte row, low six bits dropped
                            nxt_st.prog_addr = {st_ff.table_pointer[21:6], 6'h00};
                        end else begin
                            // 8-byte block, low three bits dropped
                            nxt_st.prog_addr = {st_ff.table_pointer[21:3], 3'h0};
                        end
                    end
                    // fetch refused while program space selected
                    if (wbyte[PFTA_BIT_FETCH] && !st_ff.code_space_select) begin
                        nxt_st.fetch = 1'b1;
                        nxt_st.ee_read = 1'b1;
                    end
                end
                PFTA_OFF_LATCH: begin
                    nxt_st.table_latch = wbyte;
                end
                PFTA_OFF_PTR_LOW: begin
                    nxt_st.table_pointer[7:0] = wbyte;
                end
                PFTA_OFF_PTR_HIGH: begin
                    nxt_st.table_pointer[15:8] = wbyte;
                end
                PFTA_OFF_PTR_UPPER: begin
                    nxt_st.table_pointer[21:16] = wbyte[5:0];
                end
                PFTA_OFF_TBL_CMD: begin
                    // table ops are dropped, not held, while the array is busy
                    if (!st_ff.launch) begin
                        nxt_st.table_pointer = upd_ptr;
                        if (wbyte[PFTA_BIT_STORE]) begin
                            // short write into a holding register
                            nxt_st.hold[eff_ptr[2:0]] = st_ff.table_latch;
                        end else begin
                            // full 22-bit address to the array
                            nxt_st.fl_addr = eff_ptr;
                            nxt_st.fl_rd = 1'b1;
                            nxt_st.rd_pend = 1'b1;
                            nxt_st.rd_lsb = eff_ptr[0];
                        end
                    end
                end
                PFTA_OFF_STATUS: begin
                    // firmware clears the done flag by writing zero
                    if (!wbyte[PFTA_BIT_DONE]) begin
                        nxt_st.done_flag = 1'b0;
                    end
                end
                default: begin
                    // unlock and unmapped writes store nothing
                end
            endcase
        end

        // completion sets the flag, set wins over clear
        if (tmr_done && st_ff.launch) begin
            nxt_st.done_flag = 1'b1;
        end

        // synchronous reset
        if (rst_i) begin
            nxt_st = '0;
            nxt_st.table_latch = PFTA_LATCH_RST;
            nxt_st.table_pointer = PFTA_PTR_RST;
            nxt_st.ul = PFTA_UL_IDLE;
            // cut cycle raises the flag, a held reset keeps it
            if (st_ff.launch || st_ff.aborted_flag) begin
                nxt_st.aborted_flag = 1'b1;
                // keep selects for tracing
                nxt_st.code_space_select = st_ff.code_space_select;
                nxt_st.config_space_select = st_ff.config_space_select;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register

    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign fl_addr_o = st_ff.fl_addr;
    assign fl_rd_o = st_ff.fl_rd;
    assign prog_start_o = st_ff.prog_start;
    assign prog_erase_o = st_ff.erase_sel;
    assign prog_target_o = st_ff.prog_target;
    assign prog_addr_o = st_ff.prog_addr;
    // erase ignores the latch; data is the eight holding bytes
    assign prog_data_o = st_ff.hold;
    assign ee_read_o = st_ff.ee_read;
    // core held off for the whole timed cycle
    assign stall_o = st_ff.launch;
    assign nvm_done_flag_o = st_ff.done_flag;

endmodule

// ### tb/pfta_core_properties.sv
/* pfta_core_properties: port checker for pfta_core.
   assumes: bound into pfta_core, one clock, sync reset. */
`timescale 1ns/1ps
module pfta_core_properties
    import pfta_pkg::*;
#(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [21:0] fl_addr_o,
    input wire logic fl_rd_o,
    input wire logic [15:0] fl_word_i,
    input wire logic prog_start_o,
    input wire logic prog_erase_o,
    input wire logic [1:0] prog_target_o,
    input wire logic [21:0] prog_addr_o,
    input wire logic [63:0] prog_data_o,
    input wire logic ee_read_o,
    input wire logic stall_o,
    input wire logic nvm_done_flag_o
);
    ////////////////////////////////////////////////////////////
    logic [31:0] stall_cnt_ff; // cycles stall has been high
    logic req; // new bus request
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // count stall length
    always_ff @(posedge clk_i) begin
        if (rst_i || !stall_o) begin
            stall_cnt_ff <= 32'h0;
        end else begin
            stall_cnt_ff <= stall_cnt_ff + 32'h1;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    a_unlock_reads_zero: assert property (req && !wb_we_i && wb_adr_i == PFTA_OFF_UNLOCK |=> wb_dat_o == 32'h0)
        else $error("unlock read not zero");
    a_launch_needs_write: assert property (prog_start_o |-> $past(req && wb_we_i && wb_adr_i == PFTA_OFF_CONTROL
        && wb_dat_i[PFTA_BIT_LAUNCH] && !stall_o))
        else $error("start without launch write");
    a_stall_from_start: assert property (prog_start_o |-> stall_o ##1 (stall_o && !prog_start_o))
        else $error("stall not raised by start");
    a_stall_length: assert property ($fell(stall_o) |-> stall_cnt_ff == PROG_CYCLES + 2)
        else $error("stall length wrong");
    a_done_on_end: assert property ($fell(stall_o) |-> nvm_done_flag_o)
        else $error("done flag not set");
    a_fetch_one_cycle: assert property (ee_read_o |-> $past(req && wb_we_i && wb_adr_i == PFTA_OFF_CONTROL
        && wb_dat_i[PFTA_BIT_FETCH]) ##1 !ee_read_o)
        else $error("fetch pulse wrong");
    a_table_read_cause: assert property (fl_rd_o |-> $past(req && wb_we_i && wb_adr_i == PFTA_OFF_TBL_CMD
        && !wb_dat_i[PFTA_BIT_STORE]))
        else $error("array read without table fetch");
    a_prog_addr_align: assert property (prog_start_o |-> (prog_erase_o ? prog_addr_o[5:0] == 6'h00
        : prog_addr_o[2:0] == 3'h0))
        else $error("program address not aligned");
    c_erase: cover property (prog_start_o && prog_erase_o);
    c_write: cover property (prog_start_o && !prog_erase_o);
    c_tbl_read: cover property (fl_rd_o);
endmodule
bind pfta_core pfta_core_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.*);

// ### tb/pfta_flash_model.sv
/* pfta_flash_model: program array read side seen by pfta_core.
   assumes: word wanted while the read strobe is high. */
`timescale 1ns/1ps
module pfta_flash_model (
    input wire logic [21:0] fl_addr_i,
    input wire logic fl_rd_i,
    output logic [15:0] fl_word_o
);
    logic [15:0] pat; // word content from address bits 21 to 1, bit 0 unused
    assign pat = fl_addr_i[16:1] ^ {fl_addr_i[21:17], 11'h5C3};
    // off the strobe show the inverse, never a stale word
    assign fl_word_o = fl_rd_i ? pat : ~pat;
endmodule

// ### tb/test_program_flash_table_access.sv
/* test_program_flash_table_access: self-checking bench of pfta_core.
   assumes: 20 MHz clock, timed cycle shortened to 20 cycles. */
`timescale 1ns/1ps
module test_program_flash_table_access;
    import pfta_pkg::*;
    localparam int PC = 20; // shortened timed cycle
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, fl_rd_o, prog_start_o, prog_erase_o, ee_read_o, stall_o, nvm_done_flag_o;
    logic [21:0] fl_addr_o, prog_addr_o, p;
    logic [15:0] fl_word_i;
    logic [1:0] prog_target_o;
    logic [63:0] prog_data_o;
    logic [7:0] rdat; // last read byte
    int n_mismatch = 0;
    int total_checks = 0;
    int n_start = 0;
    int n_ee = 0;
    int s0, k;
    localparam logic [21:0] PAFT [4] = '{22'h3FFFFF, 22'h200000, 22'h3FFFFE, 22'h200000};
    always #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////
    pfta_core #(.PROG_CYCLES(PC)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o), .fl_rd_o(fl_rd_o), .fl_word_i(fl_word_i),
        .prog_start_o(prog_start_o), .prog_erase_o(prog_erase_o), .prog_target_o(prog_target_o),
        .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o), .ee_read_o(ee_read_o), .stall_o(stall_o),
        .nvm_done_flag_o(nvm_done_flag_o));
    pfta_flash_model u_flash (.fl_addr_i(fl_addr_o), .fl_rd_i(fl_rd_o), .fl_word_o(fl_word_i));
    // count start and eeprom read pulses
    always @(posedge clk_i) begin
        if (prog_start_o === 1'b1) n_start++;
        if (ee_read_o === 1'b1) n_ee++;
    end
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one classic cycle, waits for ack
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 20) begin
            n_mismatch++;
            report_and_stop();
        end
        rdat = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic set_ptr(input logic [21:0] v);
        bus(1, PFTA_OFF_PTR_LOW, v[7:0]);
        bus(1, PFTA_OFF_PTR_HIGH, v[15:8]);
        bus(1, PFTA_OFF_PTR_UPPER, {2'h0, v[21:16]});
    endtask
    task automatic rd_ptr();
        bus(0, PFTA_OFF_PTR_LOW, 8'h00);
        p[7:0] = rdat;
        bus(0, PFTA_OFF_PTR_HIGH, 8'h00);
        p[15:8] = rdat;
        bus(0, PFTA_OFF_PTR_UPPER, 8'h00);
        p[21:16] = rdat[5:0];
    endtask
    function automatic logic [7:0] fbyte(input logic [21:0] a);
        logic [15:0] w;
        w = a[16:1] ^ {a[21:17], 11'h5C3};
        return a[0] ? w[15:8] : w[7:0];
    endfunction
    // unlock pair, launch, look at the start cycle (no start without permit)
    task automatic start(input logic [7:0] ctl, input logic [1:0] tgt, input logic er);
        bus(1, PFTA_OFF_CONTROL, ctl);
        bus(1, PFTA_OFF_UNLOCK, PFTA_KEY_FIRST);
        bus(1, PFTA_OFF_UNLOCK, PFTA_KEY_SECOND);
        bus(1, PFTA_OFF_CONTROL, ctl | 8'h02);
        check({prog_start_o, stall_o, prog_erase_o, prog_target_o}, {{2{ctl[2]}}, er, tgt});
    endtask
    // drop permit mid-cycle, wait for the end, clear done
    task automatic finish(input logic [7:0] ctl);
        int i;
        bus(1, PFTA_OFF_CONTROL, ctl & 8'hC0);
        for (i = 0; i < 100 && stall_o !== 1'b0; i++) @(posedge clk_i);
        check(i < 100, 1'b1);
        @(posedge clk_i);
        bus(0, PFTA_OFF_CONTROL, 8'h00);
        check(rdat & 8'h13, 8'h00);
        bus(0, PFTA_OFF_STATUS, 8'h00);
        check(rdat[PFTA_BIT_DONE], 1'b1);
        bus(1, PFTA_OFF_STATUS, 8'h00);
        bus(0, PFTA_OFF_STATUS, 8'h00);
        check(rdat, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        for (k = 1; k < 9; k++) begin
            bus(0, 8'(k * 4), 8'h00);
            check(rdat, 8'h00);
        end
        bus(1, PFTA_OFF_LATCH, 8'h5A);
        bus(0, PFTA_OFF_LATCH, 8'h00);
        check(rdat, 8'h5A);
    endtask
    task automatic t_ptr_actions();
        for (k = 0; k < 4; k++) begin
            set_ptr(22'h3FFFFF);
            bus(1, PFTA_OFF_TBL_CMD, 8'(k));
            check(fl_addr_o, (k == 3) ? 22'h200000 : 22'h3FFFFF);
            bus(0, PFTA_OFF_LATCH, 8'h00);
            check(rdat, fbyte(fl_addr_o));
            rd_ptr();
            check(p, PAFT[k]);
        end
    endtask
    task automatic t_store_launch();
        set_ptr(22'h012345);
        for (k = 0; k < 8; k++) begin
            bus(1, PFTA_OFF_LATCH, 8'(8'h10 + k));
            bus(1, PFTA_OFF_TBL_CMD, 8'h05);
        end
        start(8'h84, PFTA_TGT_FLASH, 1'b0);
        check(prog_addr_o, 22'h012348);
        check(prog_data_o, 64'h1211101716151413);
        finish(8'h84);
        start(8'hC4, PFTA_TGT_CONFIG, 1'b0);
        finish(8'hC4);
        start(8'h04, PFTA_TGT_EEPROM, 1'b0);
        finish(8'h04);
    endtask
    task automatic t_refuse_abort();
        s0 = n_start;
        start(8'h90, PFTA_TGT_EEPROM, 1'b1); // target held from the last launch
        check(n_start, s0);
        bus(1, PFTA_OFF_CONTROL, 8'h94);
        bus(1, PFTA_OFF_UNLOCK, PFTA_KEY_FIRST);
        bus(0, PFTA_OFF_UNLOCK, 8'h00);
        check(rdat, 8'h00);
        bus(1, PFTA_OFF_UNLOCK, PFTA_KEY_SECOND);
        bus(1, PFTA_OFF_CONTROL, 8'h96);
        check(n_start, s0);
        start(8'h94, PFTA_TGT_FLASH, 1'b1);
        check(prog_addr_o, 22'h012340);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, PFTA_OFF_CONTROL, 8'h00);
        check(rdat, 8'h88);
    endtask
    task automatic t_fetch();
        s0 = n_ee;
        bus(1, PFTA_OFF_CONTROL, 8'h01);
        bus(0, PFTA_OFF_CONTROL, 8'h00);
        check({n_ee - s0, rdat[0]}, {32'h1, 1'b0});
        bus(1, PFTA_OFF_CONTROL, 8'h80);
        bus(1, PFTA_OFF_CONTROL, 8'h81);
        bus(0, PFTA_OFF_CONTROL, 8'h00);
        check({n_ee - s0, rdat[0]}, {32'h1, 1'b0});
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_vals();
        t_ptr_actions();
        t_store_launch();
        t_fetch();
        t_refuse_abort();
        report_and_stop();
    end
endmodule
